// ===== common/urm_pkg.sv
// How it works
// - Take the neighbour's serial readback stream and compare its checksum with the expected value.
// - A checksum mismatch raises upset_alert: both devices need reconfiguring soon.
// - In self-check mode two independent comparators watch the same stream, errors ANDed.
// - Self-check reports an upset only when both comparators flag together.
// - Protected output goes high only when both legs release their buffers.
// - When legs disagree the leg wanting low drives the shared line low.
// - Configuration-complete low holds protected outputs low through an open-drain buffer.
// - Start-up releases user I/Os before configuration-complete goes high.
// - Stream start is recognised by the preamble of five ones then a zero.
// - The checksum is the final 11 bits of the stream, after the data section.
package urm_pkg;

    localparam int          CRC_W         = 11;
    localparam int          CNT_W         = 21;
    localparam logic [5:0]  PREAMBLE      = 6'h3e;
    localparam logic [5:0]  PRE_RST       = 6'h00;
    localparam logic [20:0] DATA_BITS_DEF = 21'h6190e;
    localparam logic [20:0] CNT_RST       = 21'h000000;
    localparam logic [10:0] CRC_RST       = 11'h000;
    localparam logic [3:0]  IO_LEAD_CYC   = 4'h4;
    localparam logic [3:0]  LEAD_RST      = 4'h0;
    localparam logic [1:0]  SYNC_RST      = 2'h0;

    typedef enum logic [1:0] {
        URM_HUNT,
        URM_DATA,
        URM_GAP,
        URM_CRC
    } urm_chk_state_type;

    typedef enum logic [1:0] {
        URM_ST_CFG,
        URM_ST_IO,
        URM_ST_RUN
    } urm_start_state_type;

endpackage : urm_pkg

// ===== common/urm_rb_if.sv
`timescale 1ns/100ps
`default_nettype none
interface urm_rb_if;
    import urm_pkg::*;

    logic             bit_stb;
    logic             bit_val;
    logic [CRC_W-1:0] expected;
    logic [CNT_W-1:0] data_bits;

    modport drv (
        output bit_stb,
        output bit_val,
        output expected,
        output data_bits
    );

    modport chk (
        input bit_stb,
        input bit_val,
        input expected,
        input data_bits
    );

endinterface : urm_rb_if
`default_nettype wire

// ===== rtl/urm_crc_chk.sv
`timescale 1ns/100ps
`default_nettype none
module urm_crc_chk
    import urm_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst_n,
    urm_rb_if.chk     rb,
    output var  logic crc_err_ff,
    output var  logic crc_ok_ff
);

    urm_chk_state_type state_ff;
    urm_chk_state_type nxt_state;
    logic [5:0]        pre_ff;
    logic [5:0]        nxt_pre;
    logic [CNT_W-1:0]  cnt_ff;
    logic [CNT_W-1:0]  nxt_cnt;
    logic [CRC_W-1:0]  crc_ff;
    logic [CRC_W-1:0]  nxt_crc;
    logic              nxt_err;
    logic              nxt_ok;

    always_comb begin
        nxt_state = state_ff;
        nxt_pre   = pre_ff;
        nxt_cnt   = cnt_ff;
        nxt_crc   = crc_ff;
        nxt_err   = 1'b0;
        nxt_ok    = 1'b0;
        if (rb.bit_stb) begin
            case (state_ff)
                URM_HUNT: begin
                    nxt_pre = {pre_ff[4:0], rb.bit_val};
                    if ({pre_ff[4:0], rb.bit_val} == PREAMBLE) begin
                        nxt_state = URM_DATA;
                        nxt_cnt   = CNT_RST;
                    end
                end
                URM_DATA: begin
                    // The data section is only counted; its contents are not checked here.
                    nxt_cnt = cnt_ff + 21'h000001;
                    if (cnt_ff == rb.data_bits - 21'h000001) begin
                        nxt_state = URM_GAP;
                    end
                end
                URM_GAP: begin
                    nxt_state = URM_CRC;
                    nxt_cnt   = CNT_RST;
                end
                URM_CRC: begin
                    nxt_crc = {crc_ff[CRC_W-2:0], rb.bit_val};
                    nxt_cnt = cnt_ff + 21'h000001;
                    if (cnt_ff == 21'(CRC_W - 1)) begin
                        nxt_state = URM_HUNT;
                        nxt_pre   = PRE_RST;
                        nxt_err   = ({crc_ff[CRC_W-2:0], rb.bit_val} != rb.expected);
                        nxt_ok    = ({crc_ff[CRC_W-2:0], rb.bit_val} == rb.expected);
                    end
                end
                default: begin
                    nxt_state = URM_HUNT;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_ff   <= URM_HUNT;
            pre_ff     <= PRE_RST;
            cnt_ff     <= CNT_RST;
            crc_ff     <= CRC_RST;
            crc_err_ff <= 1'b0;
            crc_ok_ff  <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            pre_ff     <= nxt_pre;
            cnt_ff     <= nxt_cnt;
            crc_ff     <= nxt_crc;
            crc_err_ff <= nxt_err;
            crc_ok_ff  <= nxt_ok;
        end
    end

endmodule : urm_crc_chk
`default_nettype wire

// ===== rtl/urm_top.sv
`timescale 1ns/100ps
`default_nettype none
module urm_top
    import urm_pkg::*;
#(
    parameter logic [CNT_W-1:0] DATA_BITS = DATA_BITS_DEF
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic             rb_clk_in,
    input  wire logic             rb_data_in,
    input  wire logic [CRC_W-1:0] expected_crc,
    input  wire logic             self_mode,
    input  wire logic             cfg_loaded,
    input  wire logic             crit_primary,
    input  wire logic             crit_duplicate,
    input  wire logic             crit_line_in,
    input  wire logic             done_in,
    output var  logic             upset_alert_ff,
    output var  logic             chk_a_fault_ff,
    output var  logic             chk_b_fault_ff,
    output var  logic             frame_ok_ff,
    output var  logic             io_released_ff,
    output var  logic             crit_out_ff,
    output var  logic             crit_p_oe_ff,
    output var  logic             crit_d_oe_ff,
    output var  logic             hold_out_ff,
    output var  logic             hold_oe_ff,
    output var  logic             done_out_ff,
    output var  logic             done_oe_ff,
    output var  logic             crit_level_ff
);

    // Pin synchronisers; the first stage feeds only the second.
    logic [1:0] rb_clk_s_ff;
    logic [1:0] rb_dat_s_ff;
    logic [1:0] done_s_ff;
    logic [1:0] line_s_ff;
    logic       rb_clk_d_ff;
    logic [1:0] nxt_rb_clk_s;
    logic [1:0] nxt_rb_dat_s;
    logic [1:0] nxt_done_s;
    logic [1:0] nxt_line_s;
    logic       nxt_rb_clk_d;

    always_comb begin
        nxt_rb_clk_s = {rb_clk_s_ff[0], rb_clk_in};
        nxt_rb_dat_s = {rb_dat_s_ff[0], rb_data_in};
        nxt_done_s   = {done_s_ff[0], done_in};
        nxt_line_s   = {line_s_ff[0], crit_line_in};
        nxt_rb_clk_d = rb_clk_s_ff[1];
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rb_clk_s_ff <= SYNC_RST;
            rb_dat_s_ff <= SYNC_RST;
            done_s_ff   <= SYNC_RST;
            line_s_ff   <= SYNC_RST;
            rb_clk_d_ff <= 1'b0;
        end else begin
            rb_clk_s_ff <= nxt_rb_clk_s;
            rb_dat_s_ff <= nxt_rb_dat_s;
            done_s_ff   <= nxt_done_s;
            line_s_ff   <= nxt_line_s;
            rb_clk_d_ff <= nxt_rb_clk_d;
        end
    end

    // Data is taken on the rising edge of the readback clock. At 125 MHz and a
    // readback clock of at most 2 MHz each bit is seen for dozens of cycles.
    urm_rb_if rb ();

    assign rb.bit_stb   = rb_clk_s_ff[1] & ~rb_clk_d_ff;
    assign rb.bit_val   = rb_dat_s_ff[1];
    assign rb.expected  = expected_crc;
    assign rb.data_bits = DATA_BITS;

    logic err_a;
    logic err_b;
    logic ok_a;
    logic ok_b;

    // Two separate instances so a single upset in one cannot corrupt both verdicts.
    urm_crc_chk u_chk_a (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .rb         (rb.chk),
        .crc_err_ff (err_a),
        .crc_ok_ff  (ok_a)
    );

    urm_crc_chk u_chk_b (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .rb         (rb.chk),
        .crc_err_ff (err_b),
        .crc_ok_ff  (ok_b)
    );

    // Alert and fault bookkeeping.
    logic upset_now;
    logic nxt_alert;
    logic nxt_fault_a;
    logic nxt_fault_b;
    logic nxt_frame_ok;

    always_comb begin
        upset_now    = self_mode ? (err_a & err_b) : err_a;
        nxt_alert    = upset_alert_ff | upset_now;
        // A lone error in self-check mode points at the comparator, not the device.
        nxt_fault_a  = chk_a_fault_ff | (self_mode & err_a & ~err_b);
        nxt_fault_b  = chk_b_fault_ff | (self_mode & err_b & ~err_a);
        nxt_frame_ok = self_mode ? (ok_a & ok_b) : ok_a;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            upset_alert_ff <= 1'b0;
            chk_a_fault_ff <= 1'b0;
            chk_b_fault_ff <= 1'b0;
            frame_ok_ff    <= 1'b0;
        end else begin
            upset_alert_ff <= nxt_alert;
            chk_a_fault_ff <= nxt_fault_a;
            chk_b_fault_ff <= nxt_fault_b;
            frame_ok_ff    <= nxt_frame_ok;
        end
    end

    // Start-up: I/Os are released a few cycles before configuration-complete is
    // let go, so the protected lines never float high in between.
    urm_start_state_type st_ff;
    urm_start_state_type nxt_st;
    logic [3:0]          lead_ff;
    logic [3:0]          nxt_lead;
    logic                nxt_io_rel;
    logic                nxt_done_oe;

    always_comb begin
        nxt_st      = st_ff;
        nxt_lead    = lead_ff;
        nxt_io_rel  = io_released_ff;
        nxt_done_oe = done_oe_ff;
        case (st_ff)
            URM_ST_CFG: begin
                nxt_io_rel  = 1'b0;
                nxt_done_oe = 1'b1;
                nxt_lead    = LEAD_RST;
                if (cfg_loaded) begin
                    nxt_st     = URM_ST_IO;
                    nxt_io_rel = 1'b1;
                end
            end
            URM_ST_IO: begin
                nxt_lead = lead_ff + 4'h1;
                if (lead_ff == IO_LEAD_CYC - 4'h1) begin
                    nxt_st      = URM_ST_RUN;
                    nxt_done_oe = 1'b0;
                end
            end
            URM_ST_RUN: begin
                nxt_io_rel  = 1'b1;
                nxt_done_oe = 1'b0;
            end
            default: begin
                nxt_st = URM_ST_CFG;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_ff          <= URM_ST_CFG;
            lead_ff        <= LEAD_RST;
            io_released_ff <= 1'b0;
            done_oe_ff     <= 1'b1;
        end else begin
            st_ff          <= nxt_st;
            lead_ff        <= nxt_lead;
            io_released_ff <= nxt_io_rel;
            done_oe_ff     <= nxt_done_oe;
        end
    end

    // Wired-AND protected output. Every buffer only ever drives low; high comes
    // from the external pull-up, so a single upset leg can only force low.
    logic nxt_p_oe;
    logic nxt_d_oe;
    logic nxt_hold_oe;

    always_comb begin
        nxt_p_oe    = io_released_ff & ~crit_primary;
        nxt_d_oe    = io_released_ff & ~crit_duplicate;
        nxt_hold_oe = ~done_s_ff[1];
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            crit_p_oe_ff  <= 1'b0;
            crit_d_oe_ff  <= 1'b0;
            hold_oe_ff    <= 1'b1;
            crit_out_ff   <= 1'b0;
            hold_out_ff   <= 1'b0;
            done_out_ff   <= 1'b0;
            crit_level_ff <= 1'b0;
        end else begin
            crit_p_oe_ff  <= nxt_p_oe;
            crit_d_oe_ff  <= nxt_d_oe;
            hold_oe_ff    <= nxt_hold_oe;
            crit_out_ff   <= 1'b0;
            hold_out_ff   <= 1'b0;
            done_out_ff   <= 1'b0;
            crit_level_ff <= line_s_ff[1];
        end
    end

    // Correction is a full reconfiguration done outside; the alert is the
    // request for it and stays up until this block is reset.

endmodule : urm_top
`default_nettype wire

// ===== dv/urm_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module urm_monitor
    import urm_pkg::*;
#(
    parameter logic [CNT_W-1:0] DATA_BITS = DATA_BITS_DEF
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic cfg_loaded,
    input wire logic crit_primary,
    input wire logic crit_duplicate,
    input wire logic done_in,
    input wire logic upset_alert_ff,
    input wire logic frame_ok_ff,
    input wire logic io_released_ff,
    input wire logic crit_out_ff,
    input wire logic crit_p_oe_ff,
    input wire logic crit_d_oe_ff,
    input wire logic hold_out_ff,
    input wire logic hold_oe_ff,
    input wire logic done_out_ff,
    input wire logic done_oe_ff
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence io_lead_s;
        done_oe_ff [*4] ##1 !done_oe_ff;
    endsequence

    start_order_a: assert property ($rose(io_released_ff) |-> io_lead_s)
        else $error("config complete not released four cycles after the I/Os");
    io_first_a: assert property (!io_released_ff |-> done_oe_ff)
        else $error("config complete released before the I/Os");
    cfg_start_a: assert property (cfg_loaded && !io_released_ff |=> io_released_ff)
        else $error("I/Os not released after configuration load");
    legs_off_a: assert property (!io_released_ff |-> !crit_p_oe_ff && !crit_d_oe_ff)
        else $error("leg buffer enabled before I/O release");
    leg_p_a: assert property (io_released_ff && $past(io_released_ff)
        |-> crit_p_oe_ff == !$past(crit_primary))
        else $error("primary buffer does not follow its leg");
    leg_d_a: assert property (io_released_ff && $past(io_released_ff)
        |-> crit_d_oe_ff == !$past(crit_duplicate))
        else $error("duplicate buffer does not follow its leg");
    alert_hold_a: assert property (upset_alert_ff |=> upset_alert_ff)
        else $error("upset alert dropped without reset");
    ok_pulse_a: assert property (frame_ok_ff |=> !frame_ok_ff)
        else $error("frame match held longer than one cycle");
    od_low_a: assert property (!crit_out_ff && !hold_out_ff && !done_out_ff)
        else $error("open-drain data not low");
    hold_done_a: assert property (hold_oe_ff == !$past(done_in, 3))
        else $error("hold buffer does not follow config complete");
endmodule : urm_monitor

bind urm_top urm_monitor #(.DATA_BITS(DATA_BITS)) u_mon (
    .mclk(mclk), .rst_n(rst_n), .cfg_loaded(cfg_loaded),
    .crit_primary(crit_primary), .crit_duplicate(crit_duplicate), .done_in(done_in),
    .upset_alert_ff(upset_alert_ff), .frame_ok_ff(frame_ok_ff),
    .io_released_ff(io_released_ff), .crit_out_ff(crit_out_ff),
    .crit_p_oe_ff(crit_p_oe_ff), .crit_d_oe_ff(crit_d_oe_ff), .hold_out_ff(hold_out_ff),
    .hold_oe_ff(hold_oe_ff), .done_out_ff(done_out_ff), .done_oe_ff(done_oe_ff)
);
`default_nettype wire

// ===== dv/urm_rb_src.sv
`timescale 1ns/100ps
`default_nettype none
module urm_rb_src (
    output var logic rb_clk,
    output var logic rb_data
);
    // Clock idles low between frames; data shows the inverse of its last bit.
    initial begin
        rb_clk = 1'b0;
        rb_data = 1'b0;
    end

    task automatic put(input logic b);
        rb_data = b;
        #336 rb_clk = 1'b1;
        #336 rb_clk = 1'b0;
    endtask : put

    // Two junk bits precede the start pattern so the hunt has to skip them.
    // The leading cycle keeps the idle value and the first bit in separate time steps.
    task automatic send(input logic [15:0] d, input logic [10:0] crc);
        logic [35:0] f;
        f = {8'hbe, d, 1'b0, crc};
        #8;
        for (int i = 35; i >= 0; i--) begin
            put(f[i]);
        end
        rb_data = ~f[0];
    endtask : send
endmodule : urm_rb_src
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb
    import urm_pkg::*;
();
    logic        mclk = 1'b0;
    logic        rst_n, cfg_loaded, self_mode, crit_primary, crit_duplicate;
    logic        rb_clk, rb_data, upset_alert_ff, frame_ok_ff, io_released_ff, crit_level_ff;
    logic        crit_out_ff, crit_p_oe_ff, crit_d_oe_ff, hold_out_ff, hold_oe_ff;
    logic        done_out_ff, done_oe_ff, chk_a_fault_ff, chk_b_fault_ff, alert_q = 1'b0;
    logic [10:0] expected_crc;
    logic        exp_q[$];
    int          seed, miscompares = 0, checks_done = 0;

    always #4 mclk = ~mclk;
    urm_rb_src src (.rb_clk(rb_clk), .rb_data(rb_data));
    urm_top #(.DATA_BITS(21'h000010)) dut (
        .mclk(mclk), .rst_n(rst_n), .rb_clk_in(rb_clk), .rb_data_in(rb_data),
        .expected_crc(expected_crc), .self_mode(self_mode), .cfg_loaded(cfg_loaded),
        .crit_primary(crit_primary), .crit_duplicate(crit_duplicate),
        .crit_line_in(~(crit_p_oe_ff | crit_d_oe_ff | hold_oe_ff)), .done_in(~done_oe_ff),
        .upset_alert_ff(upset_alert_ff), .chk_a_fault_ff(chk_a_fault_ff),
        .chk_b_fault_ff(chk_b_fault_ff),
        .frame_ok_ff(frame_ok_ff), .io_released_ff(io_released_ff), .crit_out_ff(crit_out_ff),
        .crit_p_oe_ff(crit_p_oe_ff), .crit_d_oe_ff(crit_d_oe_ff), .hold_out_ff(hold_out_ff),
        .hold_oe_ff(hold_oe_ff), .done_out_ff(done_out_ff), .done_oe_ff(done_oe_ff),
        .crit_level_ff(crit_level_ff)
    );

    task automatic note(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : note

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict

    task automatic tick();
        @(posedge mclk);
        #1;
    endtask : tick

    // A result is either a match pulse or the first rise of the sticky alert.
    // Sampled on the falling edge so the outputs have settled after their launch edge.
    always @(negedge mclk) begin
        if (frame_ok_ff === 1'b1 || (upset_alert_ff === 1'b1 && alert_q === 1'b0)) begin
            if (exp_q.size() == 0) note(1'b0, "unexpected frame result");
            else note(exp_q.pop_front() === frame_ok_ff, "frame result");
        end
        alert_q <= upset_alert_ff;
    end

    task automatic reset_dut();
        rst_n = 1'b0;
        cfg_loaded = 1'b0;
        repeat (20) tick();
        rst_n = 1'b1;
    endtask : reset_dut

    task automatic start_up();
        int n;
        note(done_oe_ff === 1'b1 && io_released_ff === 1'b0, "start state");
        cfg_loaded = 1'b1;
        for (n = 0; n < 12 && done_oe_ff !== 1'b0; n++) tick();
        note(done_oe_ff === 1'b0 && io_released_ff === 1'b1, "release order");
        if (done_oe_ff !== 1'b0) give_verdict();
    endtask : start_up

    task automatic legs(input logic p, input logic d, input logic lvl);
        crit_primary = p;
        crit_duplicate = d;
        repeat (6) tick();
        note(crit_level_ff === lvl, "protected line level");
    endtask : legs

    task automatic frame(input logic good, input logic sm);
        logic [10:0] crc;
        int          n;
        self_mode = sm;
        expected_crc = 11'($random(seed));
        crc = good ? expected_crc : expected_crc ^ (11'h001 << (5'($random(seed)) % 5'd11));
        exp_q.push_back(good);
        src.send(16'($random(seed)), crc);
        for (n = 0; n < 40 && exp_q.size() != 0; n++) tick();
        note(exp_q.size() == 0, "no frame result");
        if (exp_q.size() != 0) give_verdict();
    endtask : frame

    initial begin
        seed = 32'h4fc7;
        {cfg_loaded, self_mode, crit_primary, crit_duplicate} = 4'h0;
        expected_crc = 11'h000;
        reset_dut();
        legs(1'b1, 1'b1, 1'b0);
        start_up();
        for (int k = 0; k < 4; k++) legs(k[1], k[0], k[1] & k[0]);
        repeat (100) begin
            tick();
            crit_primary = 1'($random(seed));
            crit_duplicate = 1'($random(seed));
        end
        frame(1'b1, 1'b0);
        frame(1'b0, 1'b0);
        repeat (30) tick();
        note(upset_alert_ff === 1'b1, "alert dropped");
        note((chk_a_fault_ff | chk_b_fault_ff) === 1'b0, "stray fault");
        // The reset stands in for the full reconfiguration that the alert asks for.
        reset_dut();
        note(upset_alert_ff === 1'b0, "alert not cleared");
        start_up();
        frame(1'b1, 1'b1);
        frame(1'b0, 1'b1);
        note((chk_a_fault_ff | chk_b_fault_ff) === 1'b0, "lone fault");
        give_verdict();
    end
endmodule : tb
`default_nettype wire
